//--- hdl/rxg_pkg.sv
// Constants, types and helpers shared by the DDR receive gearing block
// ---------------------------------------------------------------------
// How it works
// - Lane reset clears gearbox and lane controller asynchronously
// - Lane reset holds interface PLL powered down
// - Pause pulse restarts receive gearbox state
// - Pause pulse clears all accumulated slip adjustment
// - Pause pulse restarts transmit gearbox phase
// - Even word bits rising, odd bits falling, except at three and half ratio or after a slip
// - Word width equals inputs times twice gearing ratio
// - Receive clock leaves on global or regional
// - Fractional-aligned mode reports PLL lock status
// - Training done flag once alignment finishes
// - Fractional capture clock derived from receive clock
// - Dynamic mode captures data, timing adjustable live
// - Dynamic ratios two, three and half, four, five
// - Dynamic fabric clock via lane controller, regional
// - Slip rising edge shifts one bit per slip
// - No slip in three and half ratio
// - Dynamic mode flags training that never completes
// ---------------------------------------------------------------------
package rxg_pkg;
  localparam int LANES = 11;
  localparam int WORD_W = 10;
  localparam int HIST_W = 12;
  localparam int OUT_W = LANES * WORD_W;
  localparam int LOCK_CYCLES = 64;
  localparam int TRAIN_WORDS = 8;
  localparam int TRAIN_SETTLE_CYCLES = 8;
  localparam int TRAIN_TIMEOUT_CYCLES = 1024;
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam logic [1:0] TX_PHASE_RESET = 2'h0;

  typedef enum logic [1:0] {rxg_ratio_2, rxg_ratio_3p5, rxg_ratio_4, rxg_ratio_5}
    rxg_ratio_type;

  typedef enum logic [1:0] {
    rxg_fractional_aligned_rx_mode,
    rxg_dynamic_rx_global_mode,
    rxg_dynamic_rx_regional_mode
  } rxg_mode_type;

  // Bits per lane word for each ratio
  function automatic logic [3:0] rxg_word_bits(input rxg_ratio_type r);
    case (r)
      rxg_ratio_2: return 4'h4;
      rxg_ratio_3p5: return 4'h7;
      rxg_ratio_5: return 4'hA;
      default: return 4'h8;
    endcase
  endfunction : rxg_word_bits

  // Slip is not offered at the half ratio
  function automatic logic rxg_slip_allowed(input rxg_ratio_type r);
    return r != rxg_ratio_3p5;
  endfunction : rxg_slip_allowed
endpackage : rxg_pkg

//--- hdl/rxg_gear_if.sv
// Link-domain carrier between lane controller and gearbox
interface rxg_gear_if;
  import rxg_pkg::*;
  rxg_ratio_type ratio;
  logic cap_en;
  logic gear_clear;
  logic [LANES-1:0] slip;
  logic [LANES-1:0] rise_bit;
  logic [LANES-1:0] fall_bit;
  logic [LANES-1:0][WORD_W-1:0] word;
  logic [LANES-1:0] word_valid;

  modport ctrl (output ratio, cap_en, gear_clear, slip, rise_bit, fall_bit,
    input word, word_valid);
  modport gear (input ratio, cap_en, gear_clear, slip, rise_bit, fall_bit,
    output word, word_valid);
endinterface : rxg_gear_if

//--- hdl/rxg_lane_gearbox.sv
// Per-lane DDR bit accumulator that cuts the stream into words
module rxg_lane_gearbox (
  // Link clock and lane reset
  input wire logic link_clk,
  input wire logic lane_async_reset_low,
  // Controller side
  rxg_gear_if.gear gear
);
  import rxg_pkg::*;

  logic [HIST_W-1:0] hist_q [LANES];
  logic [HIST_W-1:0] hist_d [LANES];
  logic [3:0] cnt_q [LANES];
  logic [3:0] cnt_d [LANES];
  logic [LANES-1:0][WORD_W-1:0] word_q;
  logic [LANES-1:0][WORD_W-1:0] word_d;
  logic [LANES-1:0] valid_q;
  logic [LANES-1:0] valid_d;

  // Oldest bit of the window lands in bit 0
  function automatic logic [WORD_W-1:0] pick_word(input logic [HIST_W-1:0] h,
    input int lo, input int w);
    logic [WORD_W-1:0] r;
    r = '0;
    for (int i = 0; i < WORD_W; i++)
    begin
      if (i < w)
        r[i] = h[lo + w - 1 - i];
    end
    return r;
  endfunction : pick_word

  // Two bits per link cycle; a slip counts one, so one bit is dropped
  always_comb
  begin
    int w;
    int step;
    int acc;
    w = int'(rxg_word_bits(gear.ratio));
    step = 2;
    acc = 0;
    for (int l = 0; l < LANES; l++)
    begin
      hist_d[l] = hist_q[l];
      cnt_d[l] = cnt_q[l];
      word_d[l] = word_q[l];
      valid_d[l] = 1'b0;
      if (gear.gear_clear)
      begin
        hist_d[l] = '0;
        cnt_d[l] = CNT_RESET;
      end
      else if (gear.cap_en)
      begin
        step = gear.slip[l] ? 1 : 2;
        acc = int'(cnt_q[l]) + step;
        hist_d[l] = {hist_q[l][HIST_W-3:0], gear.rise_bit[l], gear.fall_bit[l]};
        if (acc >= w)
        begin
          word_d[l] = pick_word(hist_d[l], acc - w, w);
          valid_d[l] = 1'b1;
          cnt_d[l] = 4'(acc - w);
        end
        else
          cnt_d[l] = 4'(acc);
      end
    end
  end

  // Gearbox state, cleared by the lane reset at once
  always_ff @(posedge link_clk or negedge lane_async_reset_low)
  begin
    if (!lane_async_reset_low)
    begin
      for (int l = 0; l < LANES; l++)
      begin
        hist_q[l] <= '0;
        cnt_q[l] <= CNT_RESET;
      end
      word_q <= '0;
      valid_q <= '0;
    end
    else
    begin
      hist_q <= hist_d;
      cnt_q <= cnt_d;
      word_q <= word_d;
      valid_q <= valid_d;
    end
  end

  assign gear.word = word_q;
  assign gear.word_valid = valid_q;
endmodule : rxg_lane_gearbox

//--- hdl/rxg_clock_trainer.sv
// Training sequencer between bank clock and system clock
module rxg_clock_trainer (
  // System clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Control
  input wire logic restart,
  input wire logic enable,
  input wire logic gear_running,
  input wire logic report_error,
  // Status
  output logic done,
  output logic failed
);
  import rxg_pkg::*;

  typedef enum {rxg_trn_idle, rxg_trn_active, rxg_trn_done, rxg_trn_failed}
    rxg_train_state_type;

  rxg_train_state_type state_q;
  logic [10:0] cnt_q;

  // Settle first so a stale running flag from before a pause is ignored
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      state_q <= rxg_trn_idle;
      cnt_q <= '0;
    end
    else
    begin
      case (state_q)
        rxg_trn_idle:
        begin
          cnt_q <= '0;
          if (enable)
            state_q <= rxg_trn_active;
        end
        rxg_trn_active:
        begin
          if (!enable)
            state_q <= rxg_trn_idle;
          else if (restart)
            cnt_q <= '0;
          else if (cnt_q >= 11'(TRAIN_SETTLE_CYCLES) && gear_running)
            state_q <= rxg_trn_done;
          else if (cnt_q == 11'(TRAIN_TIMEOUT_CYCLES - 1))
            state_q <= rxg_trn_failed;
          else
            cnt_q <= cnt_q + 11'h001;
        end
        default:
        begin
          cnt_q <= '0;
          if (!enable)
            state_q <= rxg_trn_idle;
          else if (restart)
            state_q <= rxg_trn_active;
        end
      endcase
    end
  end

  assign done = state_q == rxg_trn_done;
  assign failed = report_error && state_q == rxg_trn_failed;
endmodule : rxg_clock_trainer

//--- hdl/rxg_ddr_rx_gearing.sv
// Top of the DDR receive gearing block: capture, lane control, status
module rxg_ddr_rx_gearing (
  // System clock and resets
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic lane_async_reset_low,
  // Mode and gearing selection, quasi-static
  input wire rxg_pkg::rxg_mode_type rx_mode_sel,
  input wire rxg_pkg::rxg_ratio_type ratio_sel,
  // Fabric control, system domain
  input wire logic fast_clock_pause,
  input wire logic [rxg_pkg::LANES-1:0] word_align_slip,
  // Link pins from the transmitter
  input wire logic rx_link_clock,
  input wire logic [rxg_pkg::LANES-1:0] rx_data,
  // Fabric data and clocks, link domain
  output logic [rxg_pkg::OUT_W-1:0] dyn_lane_rx_word,
  output logic [rxg_pkg::LANES-1:0] rx_word_valid,
  output logic rx_clock_global,
  output logic fabric_side_rx_clock,
  // Status, system domain
  output logic pll_lock_status,
  output logic pll_power_down,
  output logic clock_training_complete,
  output logic clock_training_failed,
  output logic [1:0] tx_gear_phase
);
  import rxg_pkg::*;

  // -------------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------------
  rxg_gear_if gear_bus ();

  // System-domain event capture
  logic pause_prev_q;
  logic pause_evt;
  logic pause_tgl_q;
  logic [LANES-1:0] slip_prev_q;
  logic [LANES-1:0] slip_tgl_q;
  logic [1:0] tx_phase_q;
  logic power_down_q;

  // Link-domain synchronisers
  rxg_mode_type mode_s1_q;
  rxg_mode_type mode_s2_q;
  rxg_ratio_type ratio_s1_q;
  rxg_ratio_type ratio_s2_q;
  logic pause_s1_q;
  logic pause_s2_q;
  logic pause_s3_q;
  logic [LANES-1:0] slip_s1_q;
  logic [LANES-1:0] slip_s2_q;
  logic [LANES-1:0] slip_s3_q;

  // Link-domain capture and lane control
  logic [LANES-1:0] rise_q;
  logic [LANES-1:0] fall_q;
  logic [6:0] lock_cnt_q;
  logic lock_q;
  logic [3:0] run_cnt_q;
  logic run_q;
  logic link_fractional;
  logic link_regional;
  logic gear_clear;

  // Link-domain outputs
  logic [LANES-1:0][WORD_W-1:0] word_out_q;
  logic [LANES-1:0] valid_out_q;
  logic clk_global_q;
  logic clk_regional_q;

  // System-domain status
  logic lock_s1_q;
  logic lock_s2_q;
  logic lock_prev_q;
  logic run_s1_q;
  logic run_s2_q;
  logic sys_fractional;
  logic train_restart;
  logic train_enable;
  logic train_done;
  logic train_failed;
  logic done_q;
  logic failed_q;
  logic lock_status_q;

  // -------------------------------------------------------------------
  // System-domain events
  // -------------------------------------------------------------------

  // Only the rising edge of the pause counts
  assign pause_evt = fast_clock_pause && !pause_prev_q;

  // Pause becomes a toggle so the slower side never misses it
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      pause_prev_q <= 1'b0;
      pause_tgl_q <= 1'b0;
    end
    else
    begin
      pause_prev_q <= fast_clock_pause;
      if (pause_evt)
        pause_tgl_q <= ~pause_tgl_q;
    end
  end

  // Each slip rising edge flips that lane's toggle
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      slip_prev_q <= '0;
      slip_tgl_q <= '0;
    end
    else
    begin
      slip_prev_q <= word_align_slip;
      slip_tgl_q <= slip_tgl_q ^ (word_align_slip & ~slip_prev_q);
    end
  end

  // Transmit gearbox phase, realigned by each pause
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      tx_phase_q <= TX_PHASE_RESET;
    else if (pause_evt)
      tx_phase_q <= TX_PHASE_RESET;
    else
      tx_phase_q <= tx_phase_q + 2'h1;
  end

  // Power-down asserts with the lane reset, without waiting for a clock
  always_ff @(posedge sys_clk or negedge lane_async_reset_low)
  begin
    if (!lane_async_reset_low)
      power_down_q <= 1'b1;
    else
      power_down_q <= ~reset_n;
  end

  // -------------------------------------------------------------------
  // Link-domain crossings
  // -------------------------------------------------------------------

  // Mode and ratio change only while idle, so bit skew is harmless
  always_ff @(posedge rx_link_clock or negedge lane_async_reset_low)
  begin
    if (!lane_async_reset_low)
    begin
      mode_s1_q <= rxg_fractional_aligned_rx_mode;
      mode_s2_q <= rxg_fractional_aligned_rx_mode;
      ratio_s1_q <= rxg_ratio_4;
      ratio_s2_q <= rxg_ratio_4;
    end
    else
    begin
      mode_s1_q <= rx_mode_sel;
      mode_s2_q <= mode_s1_q;
      ratio_s1_q <= ratio_sel;
      ratio_s2_q <= ratio_s1_q;
    end
  end

  // Pause and slip toggles: two stages, then an edge stage
  always_ff @(posedge rx_link_clock or negedge lane_async_reset_low)
  begin
    if (!lane_async_reset_low)
    begin
      pause_s1_q <= 1'b0;
      pause_s2_q <= 1'b0;
      pause_s3_q <= 1'b0;
      slip_s1_q <= '0;
      slip_s2_q <= '0;
      slip_s3_q <= '0;
    end
    else
    begin
      pause_s1_q <= pause_tgl_q;
      pause_s2_q <= pause_s1_q;
      pause_s3_q <= pause_s2_q;
      slip_s1_q <= slip_tgl_q;
      slip_s2_q <= slip_s1_q;
      slip_s3_q <= slip_s2_q;
    end
  end

  assign gear_clear = pause_s2_q ^ pause_s3_q;
  assign link_fractional = mode_s2_q == rxg_fractional_aligned_rx_mode;
  assign link_regional = mode_s2_q == rxg_dynamic_rx_regional_mode;

  // -------------------------------------------------------------------
  // DDR capture
  // -------------------------------------------------------------------

  // Rising-edge sample of each data pin
  always_ff @(posedge rx_link_clock or negedge lane_async_reset_low)
  begin
    if (!lane_async_reset_low)
      rise_q <= '0;
    else
      rise_q <= rx_data;
  end

  // Falling-edge sample; gives only half a cycle to the gearbox
  always_ff @(negedge rx_link_clock or negedge lane_async_reset_low)
  begin
    if (!lane_async_reset_low)
      fall_q <= '0;
    else
      fall_q <= rx_data;
  end

  // -------------------------------------------------------------------
  // Lane controller
  // -------------------------------------------------------------------

  // Clock-path PLL model: locks after a run of reference edges
  always_ff @(posedge rx_link_clock or negedge lane_async_reset_low)
  begin
    if (!lane_async_reset_low)
    begin
      lock_cnt_q <= '0;
      lock_q <= 1'b0;
    end
    else if (lock_cnt_q == 7'(LOCK_CYCLES - 1))
      lock_q <= 1'b1;
    else
      lock_cnt_q <= lock_cnt_q + 7'h01;
  end

  // Words seen on lane 0 since the last pause
  always_ff @(posedge rx_link_clock or negedge lane_async_reset_low)
  begin
    if (!lane_async_reset_low)
    begin
      run_cnt_q <= CNT_RESET;
      run_q <= 1'b0;
    end
    else if (gear_clear)
    begin
      run_cnt_q <= CNT_RESET;
      run_q <= 1'b0;
    end
    else if (gear_bus.word_valid[0] && !run_q)
    begin
      run_cnt_q <= run_cnt_q + 4'h1;
      run_q <= run_cnt_q == 4'(TRAIN_WORDS - 1);
    end
  end

  // Gearbox steering; fractional mode captures only on a locked clock
  assign gear_bus.ratio = ratio_s2_q;
  assign gear_bus.cap_en = link_fractional ? lock_q : 1'b1;
  assign gear_bus.gear_clear = gear_clear;
  assign gear_bus.slip = (slip_s2_q ^ slip_s3_q)
    & {LANES{rxg_slip_allowed(ratio_s2_q)}};
  assign gear_bus.rise_bit = rise_q;
  assign gear_bus.fall_bit = fall_q;

  rxg_lane_gearbox u_gearbox (
    .link_clk (rx_link_clock),
    .lane_async_reset_low (lane_async_reset_low),
    .gear (gear_bus.gear)
  );

  // -------------------------------------------------------------------
  // Fabric outputs
  // -------------------------------------------------------------------

  // Each lane's word holds until that lane delivers the next one
  always_ff @(posedge rx_link_clock or negedge lane_async_reset_low)
  begin
    if (!lane_async_reset_low)
    begin
      word_out_q <= '0;
      valid_out_q <= '0;
    end
    else
    begin
      for (int l = 0; l < LANES; l++)
      begin
        if (gear_bus.word_valid[l])
          word_out_q[l] <= gear_bus.word[l];
      end
      valid_out_q <= gear_bus.word_valid;
    end
  end

  // Word-rate clock: high one link cycle per lane 0 word, not 50% duty
  always_ff @(posedge rx_link_clock or negedge lane_async_reset_low)
  begin
    if (!lane_async_reset_low)
    begin
      clk_global_q <= 1'b0;
      clk_regional_q <= 1'b0;
    end
    else
    begin
      clk_global_q <= gear_bus.word_valid[0] && !link_regional;
      clk_regional_q <= gear_bus.word_valid[0] && link_regional;
    end
  end

  assign dyn_lane_rx_word = word_out_q;
  assign rx_word_valid = valid_out_q;
  assign rx_clock_global = clk_global_q;
  assign fabric_side_rx_clock = clk_regional_q;

  // -------------------------------------------------------------------
  // System-domain status
  // -------------------------------------------------------------------

  // Lock and running flags are levels: two stages each
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      lock_s1_q <= 1'b0;
      lock_s2_q <= 1'b0;
      lock_prev_q <= 1'b0;
      run_s1_q <= 1'b0;
      run_s2_q <= 1'b0;
    end
    else
    begin
      lock_s1_q <= lock_q;
      lock_s2_q <= lock_s1_q;
      lock_prev_q <= lock_s2_q;
      run_s1_q <= run_q;
      run_s2_q <= run_s1_q;
    end
  end

  // Training waits for lock in fractional mode and reruns on pause
  assign sys_fractional = rx_mode_sel == rxg_fractional_aligned_rx_mode;
  assign train_enable = !sys_fractional || lock_s2_q;
  assign train_restart = pause_evt || (lock_s2_q && !lock_prev_q);

  rxg_clock_trainer u_trainer (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .restart (train_restart),
    .enable (train_enable),
    .gear_running (run_s2_q),
    .report_error (!sys_fractional),
    .done (train_done),
    .failed (train_failed)
  );

  // Status outputs, registered
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      done_q <= 1'b0;
      failed_q <= 1'b0;
      lock_status_q <= 1'b0;
    end
    else
    begin
      done_q <= train_done;
      failed_q <= train_failed;
      lock_status_q <= lock_s2_q && sys_fractional;
    end
  end

  assign clock_training_complete = done_q;
  assign clock_training_failed = failed_q;
  assign pll_lock_status = lock_status_q;
  assign pll_power_down = power_down_q;
  assign tx_gear_phase = tx_phase_q;
endmodule : rxg_ddr_rx_gearing

//--- verif/rxg_tx_model.sv
// Behavioural DDR transmitter: link clock plus per-lane data
module rxg_tx_model (
  // Bench control
  input wire logic run,
  input wire logic [rxg_pkg::LANES-1:0] rise_val,
  input wire logic [rxg_pkg::LANES-1:0] fall_val,
  // Link pins, at most eleven lanes wide
  output logic link_clk,
  output logic [rxg_pkg::LANES-1:0] link_data
);
  timeunit 1ns;
  timeprecision 100ps;
  import rxg_pkg::*;
  // Data leads each edge by a quarter period; clock stands still when stopped
  initial
  begin
    link_clk = 1'b0;
    link_data = '0;
    #3;
    forever
    begin
      #8 link_data = run ? rise_val : ~link_data;
      #8 link_clk = run;
      #8 link_data = run ? fall_val : ~link_data;
      #8 link_clk = 1'b0;
    end
  end
endmodule : rxg_tx_model

//--- verif/rxg_ddr_rx_gearing_chk.sv
// Port-level checker for the DDR receive gearing top
module rxg_ddr_rx_gearing_chk (
  // Clocks and resets
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic lane_async_reset_low,
  input wire logic rx_link_clock,
  // Selection and control
  input wire rxg_pkg::rxg_mode_type rx_mode_sel,
  input wire rxg_pkg::rxg_ratio_type ratio_sel,
  input wire logic fast_clock_pause,
  // Observed outputs
  input wire logic [rxg_pkg::LANES-1:0] rx_word_valid,
  input wire logic rx_clock_global,
  input wire logic fabric_side_rx_clock,
  input wire logic pll_lock_status,
  input wire logic pll_power_down,
  input wire logic clock_training_complete,
  input wire logic clock_training_failed,
  input wire logic [1:0] tx_gear_phase
);
  timeunit 1ns;
  timeprecision 100ps;
  import rxg_pkg::*;
  // ---------------------------------------------------------------
  // System domain
  // ---------------------------------------------------------------
  property p_pwr_down;
    @(posedge sys_clk) disable iff (!reset_n) !lane_async_reset_low |-> pll_power_down;
  endproperty
  a_pwr_down: assert property (p_pwr_down) else $error("pll not powered down");
  property p_lane_rst;
    @(posedge sys_clk) disable iff (!reset_n)
      !lane_async_reset_low |-> rx_word_valid == '0 && !rx_clock_global;
  endproperty
  a_lane_rst: assert property (p_lane_rst) else $error("link outputs not cleared");
  property p_phase;
    @(posedge sys_clk) disable iff (!reset_n) $rose(fast_clock_pause) |=> tx_gear_phase == 2'h0;
  endproperty
  a_phase: assert property (p_phase) else $error("tx phase not zeroed");
  property p_lock_mode;
    @(posedge sys_clk) disable iff (!reset_n)
      rx_mode_sel != rxg_fractional_aligned_rx_mode |-> !pll_lock_status;
  endproperty
  a_lock_mode: assert property (p_lock_mode) else $error("lock shown in dynamic mode");
  property p_fail_mode;
    @(posedge sys_clk) disable iff (!reset_n)
      rx_mode_sel == rxg_fractional_aligned_rx_mode |-> !clock_training_failed;
  endproperty
  a_fail_mode: assert property (p_fail_mode) else $error("fail flag in fractional");
  property p_status;
    @(posedge sys_clk) disable iff (!reset_n) !(clock_training_complete && clock_training_failed);
  endproperty
  a_status: assert property (p_status) else $error("done and failed together");
  // ---------------------------------------------------------------
  // Link domain
  // ---------------------------------------------------------------
  property p_clk_sel;
    @(posedge rx_link_clock) disable iff (!lane_async_reset_low)
      rx_word_valid[0] |-> (rx_clock_global != fabric_side_rx_clock) &&
      (fabric_side_rx_clock == (rx_mode_sel == rxg_dynamic_rx_regional_mode));
  endproperty
  a_clk_sel: assert property (p_clk_sel) else $error("wrong fabric clock path");
  property p_gap4;
    @(posedge rx_link_clock) disable iff (!lane_async_reset_low)
      ratio_sel == rxg_ratio_4 && rx_word_valid[0] |=> !rx_word_valid[0] [*3];
  endproperty
  a_gap4: assert property (p_gap4) else $error("ratio 4 words too close");
endmodule : rxg_ddr_rx_gearing_chk

bind rxg_ddr_rx_gearing rxg_ddr_rx_gearing_chk i_rxg_ddr_rx_gearing_chk (.sys_clk, .reset_n,
  .lane_async_reset_low, .rx_link_clock, .rx_mode_sel, .ratio_sel, .fast_clock_pause,
  .rx_word_valid, .rx_clock_global, .fabric_side_rx_clock, .pll_lock_status,
  .pll_power_down, .clock_training_complete, .clock_training_failed, .tx_gear_phase);

//--- verif/tb_top.sv
// Self-checking bench for the DDR receive gearing top
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import rxg_pkg::*;
  logic sys_clk, reset_n, lane_async_reset_low, fast_clock_pause, run, rx_link_clock;
  rxg_mode_type rx_mode_sel;
  rxg_ratio_type ratio_sel;
  logic [LANES-1:0] word_align_slip, rx_data, rx_word_valid;
  logic [OUT_W-1:0] dyn_lane_rx_word;
  logic rx_clock_global, fabric_side_rx_clock, pll_lock_status, pll_power_down;
  logic clock_training_complete, clock_training_failed;
  logic [1:0] tx_gear_phase;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  int g1, g2, g3;
  // Per-ratio expectations: two-word gap sum, word mask, aligned word
  int gsum [4] = '{4, 7, 8, 10};
  logic [9:0] wmask [4] = '{10'h00F, 10'h07F, 10'h0FF, 10'h3FF};
  logic [9:0] wexp [4] = '{10'h005, 10'h055, 10'h055, 10'h155};
  // ---------------------------------------------------------------
  // Clock, partner and design
  // ---------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  rxg_tx_model i_rxg_tx_model (.run(run), .rise_val({LANES{1'b1}}), .fall_val({LANES{1'b0}}),
    .link_clk(rx_link_clock), .link_data(rx_data));
  rxg_ddr_rx_gearing i_rxg_ddr_rx_gearing (.sys_clk(sys_clk), .reset_n(reset_n),
    .lane_async_reset_low(lane_async_reset_low), .rx_mode_sel(rx_mode_sel),
    .ratio_sel(ratio_sel), .fast_clock_pause(fast_clock_pause),
    .word_align_slip(word_align_slip), .rx_link_clock(rx_link_clock), .rx_data(rx_data),
    .dyn_lane_rx_word(dyn_lane_rx_word), .rx_word_valid(rx_word_valid),
    .rx_clock_global(rx_clock_global), .fabric_side_rx_clock(fabric_side_rx_clock),
    .pll_lock_status(pll_lock_status), .pll_power_down(pll_power_down),
    .clock_training_complete(clock_training_complete),
    .clock_training_failed(clock_training_failed), .tx_gear_phase(tx_gear_phase));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Lane reset one cycle before system reset, both released together; lane reset lands between edges to show it is async
  task automatic setup(input rxg_mode_type m, input rxg_ratio_type r);
    @(negedge sys_clk);
    #7 lane_async_reset_low = 1'b0;
    #1 check(pll_power_down, 1'b1);
    check(rx_word_valid, '0);
    @(negedge sys_clk);
    reset_n = 1'b0;
    rx_mode_sel = m;
    ratio_sel = r;
    repeat (4) @(negedge sys_clk);
    reset_n = 1'b1;
    lane_async_reset_low = 1'b1;
    repeat (2) @(negedge sys_clk);
  endtask : setup
  // Link cycles until the next lane 0 word
  task automatic gap(output int n);
    n = 0;
    do
    begin
      @(negedge rx_link_clock);
      n++;
    end
    while (rx_word_valid[0] !== 1'b1 && n < 200);
  endtask : gap
  task automatic pulse(input int lane);
    @(negedge sys_clk);
    if (lane < 0)
      fast_clock_pause = 1'b1;
    else
      word_align_slip[lane] = 1'b1;
    repeat (4) @(negedge sys_clk);
    fast_clock_pause = 1'b0;
    word_align_slip = '0;
    repeat (4) @(negedge sys_clk);
  endtask : pulse
  task automatic wait_sys(input int lim, ref logic sig);
    for (int i = 0; i < lim && sig !== 1'b1; i++)
      @(negedge sys_clk);
  endtask : wait_sys
  // Cycle ceiling against hangs
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      close_out();
    end
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    reset_n = 1'b0;
    lane_async_reset_low = 1'b0;
    fast_clock_pause = 1'b0;
    word_align_slip = '0;
    run = 1'b1;
    rx_mode_sel = rxg_dynamic_rx_global_mode;
    ratio_sel = rxg_ratio_4;
    // Every ratio: word rate; width and rising bits on even positions except at three and half
    for (int r = 0; r < 4; r++)
    begin
      setup(rxg_dynamic_rx_global_mode, rxg_ratio_type'(r));
      repeat (4) gap(g1);
      gap(g2);
      gap(g3);
      check(g2 + g3, gsum[r]);
      if (r != 1)
        check(dyn_lane_rx_word[9:0] & wmask[r], wexp[r]);
    end
    // Slip moves lane 1 by one bit, pause undoes it
    setup(rxg_dynamic_rx_regional_mode, rxg_ratio_4);
    wait_sys(300, clock_training_complete);
    check(clock_training_complete, 1'b1);
    pulse(1);
    repeat (3) gap(g1);
    check(dyn_lane_rx_word[17:10], 8'hAA);
    check(dyn_lane_rx_word[7:0], 8'h55);
    pulse(-1);
    repeat (3) gap(g1);
    check(dyn_lane_rx_word[17:10], 8'h55);
    // Half ratio ignores slip
    setup(rxg_dynamic_rx_regional_mode, rxg_ratio_3p5);
    repeat (3) gap(g1);
    pulse(1);
    repeat (3) gap(g1);
    check(dyn_lane_rx_word[16:10], dyn_lane_rx_word[6:0]);
    // Fractional: lock, pause after lock, phase restart, training
    setup(rxg_fractional_aligned_rx_mode, rxg_ratio_4);
    check(pll_lock_status, 1'b0);
    wait_sys(300, pll_lock_status);
    check(pll_lock_status, 1'b1);
    @(negedge sys_clk);
    fast_clock_pause = 1'b1;
    @(negedge sys_clk);
    check(tx_gear_phase, 2'h0);
    fast_clock_pause = 1'b0;
    @(negedge sys_clk);
    check(tx_gear_phase, 2'h1);
    wait_sys(300, clock_training_complete);
    check(clock_training_complete, 1'b1);
    gap(g1);
    check(dyn_lane_rx_word[7:0], 8'h55);
    // Dynamic training with the link stopped must time out
    setup(rxg_dynamic_rx_global_mode, rxg_ratio_4);
    run = 1'b0;
    pulse(-1);
    wait_sys(1200, clock_training_failed);
    check(clock_training_failed, 1'b1);
    check(clock_training_complete, 1'b0);
    close_out();
  end
endmodule : tb_top
